// file: flag_source_model.sv
// behavioural model of the eight peripheral flag sources
`default_nettype none

module flag_source (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pattern the bench wants raised
  input wire logic [7:0] want,
  // flag levels, bit order as the enable register
  output logic port_b_change_flag,
  output logic timer_three_flag,
  output logic timer_two_flag,
  output logic timer_one_flag,
  output logic capture_two_flag,
  output logic capture_one_flag,
  output logic serial_one_tx_empty_flag,
  output logic serial_one_rx_full_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // sources hold levels; clearing is theirs, not the bank's
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      {port_b_change_flag, timer_three_flag, timer_two_flag, timer_one_flag, capture_two_flag,
       capture_one_flag, serial_one_tx_empty_flag, serial_one_rx_full_flag} <= 8'h00;
    else
      {port_b_change_flag, timer_three_flag, timer_two_flag, timer_one_flag, capture_two_flag,
       capture_one_flag, serial_one_tx_empty_flag, serial_one_rx_full_flag} <= want;
endmodule

`default_nettype wire

// file: irq_enable_pkg.sv
// shared constants and carrier types for the peripheral interrupt enable bank
`default_nettype none

package irq_enable_pkg;

  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // register map
  // ==========================================================================
  // offsets are word indices: a register's byte address is four times its index
  localparam logic [11:0] ENABLE_ONE_OFFSET = 12'h017;
  localparam logic [11:0] FLAGS_OFFSET = 12'h018;
  localparam logic [11:0] REQUEST_OFFSET = 12'h01C;
  localparam logic [7:0] ENABLE_ONE_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

  // ==========================================================================
  // bit positions of the enable register and of the flag vector
  // ==========================================================================
  localparam int SERIAL_ONE_RX_FULL_BIT = 0;
  localparam int SERIAL_ONE_TX_EMPTY_BIT = 1;
  localparam int CAPTURE_ONE_BIT = 2;
  localparam int CAPTURE_TWO_BIT = 3;
  localparam int TIMER_ONE_BIT = 4;
  localparam int TIMER_TWO_BIT = 5;
  localparam int TIMER_THREE_BIT = 6;
  localparam int PORT_B_CHANGE_BIT = 7;

  // ==========================================================================
  // bus answers
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic port_b_change_irq_en;
    logic timer_three_irq_en;
    logic timer_two_irq_en;
    logic timer_one_irq_en;
    logic capture_two_irq_en;
    logic capture_one_irq_en;
    logic serial_one_tx_empty_irq_en;
    logic serial_one_rx_full_irq_en;
  } enable_one_t;

  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
  } read_answer_t;

endpackage

`default_nettype wire

// file: irq_enable_properties.sv
// checker for bus handshakes and request gating of the enable bank
`default_nettype none

module irq_enable_properties (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // request side
  input wire logic [7:0] gated_flags,
  input wire logic periph_irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_WR_REFUSE: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken twice");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer unstable");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_REQ_OR: assert property (periph_irq_req == (|gated_flags))
    else $error("request not the or of gated flags");
endmodule

`default_nettype wire

// file: irq_gate.sv
// per-source gating and request reduction of the peripheral interrupt flags
`default_nettype none

module irq_gate #(
  parameter int SOURCES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sources and enables
  input wire logic [SOURCES-1:0] flags,
  input wire logic [SOURCES-1:0] enables,
  // results
  output logic [SOURCES-1:0] gated_r,
  output logic request_r
);

  timeunit 1ns;
  timeprecision 1ps;

  logic [SOURCES-1:0] gated_nxt;
  logic request_nxt;

  // ==========================================================================
  // gating
  // ==========================================================================
  // each source sees only its own enable bit
  always_comb
  begin
    gated_nxt = flags & enables;
    request_nxt = |gated_nxt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gated_r <= '0;
      request_r <= 1'b0;
    end
    else
    begin
      gated_r <= gated_nxt;
      request_r <= request_nxt;
    end
  end

endmodule

`default_nettype wire

// file: peripheral_irq_enable_bank.sv
// peripheral interrupt enable bank with AXI4-Lite register slave
// Operation
// - one 8-bit register, one enable per peripheral source, at offset 17h.
// - all bits read/write by software and clear to zero on reset.
// - bit 7 enables the port B change-detect interrupt.
// - bit 6 enables the third timer interrupt.
// - bit 5 enables the second timer interrupt.
// - bit 4 enables the first timer interrupt.
// - bit 3 enables the second capture unit interrupt.
// - bit 2 enables the first capture unit interrupt.
// - bit 1 enables the serial port one transmit-empty interrupt.
// - bit 0 enables the serial port one receive-full interrupt.
// - the register only gates sources; each bit acts independently.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none

module peripheral_irq_enable_bank (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral flag sources
  input wire logic port_b_change_flag,
  input wire logic timer_three_flag,
  input wire logic timer_two_flag,
  input wire logic timer_one_flag,
  input wire logic capture_two_flag,
  input wire logic capture_one_flag,
  input wire logic serial_one_tx_empty_flag,
  input wire logic serial_one_rx_full_flag,
  // interrupt request to the core
  output logic [7:0] gated_flags,
  output logic periph_irq_req
);

  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // enable register and flag vector
  // ==========================================================================
  irq_enable_pkg::enable_one_t peripheral_irq_enable_one_r;
  irq_enable_pkg::enable_one_t peripheral_irq_enable_one_nxt;
  logic [7:0] flags;
  logic [7:0] flags_meta_r;
  logic [7:0] flags_sync_r;

  // flags placed in the enable register's bit order
  always_comb
  begin
    flags = '0;
    flags[irq_enable_pkg::PORT_B_CHANGE_BIT] = port_b_change_flag;
    flags[irq_enable_pkg::TIMER_THREE_BIT] = timer_three_flag;
    flags[irq_enable_pkg::TIMER_TWO_BIT] = timer_two_flag;
    flags[irq_enable_pkg::TIMER_ONE_BIT] = timer_one_flag;
    flags[irq_enable_pkg::CAPTURE_TWO_BIT] = capture_two_flag;
    flags[irq_enable_pkg::CAPTURE_ONE_BIT] = capture_one_flag;
    flags[irq_enable_pkg::SERIAL_ONE_TX_EMPTY_BIT] = serial_one_tx_empty_flag;
    flags[irq_enable_pkg::SERIAL_ONE_RX_FULL_BIT] = serial_one_rx_full_flag;
  end

  // flags arrive from outside this block's timing, so two stages first
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_meta_r <= '0;
      flags_sync_r <= '0;
    end
    else
    begin
      flags_meta_r <= flags;
      flags_sync_r <= flags_meta_r;
    end
  end

  // ==========================================================================
  // write channel state
  // ==========================================================================
  logic aw_held_r;
  logic aw_held_nxt;
  logic [11:0] aw_addr_r;
  logic [11:0] aw_addr_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0] w_strb_r;
  logic [3:0] w_strb_nxt;
  logic awready_r;
  logic awready_nxt;
  logic wready_r;
  logic wready_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic aw_take;
  logic w_take;
  logic do_write;

  // one register per aligned word; the low address bits select no byte
  function automatic logic at_index(input logic [11:0] addr, input logic [11:0] index);
    at_index = (addr[11:2] == index[9:0]);
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = at_index(addr, irq_enable_pkg::ENABLE_ONE_OFFSET)
             || at_index(addr, irq_enable_pkg::FLAGS_OFFSET)
             || at_index(addr, irq_enable_pkg::REQUEST_OFFSET);
  endfunction

  assign aw_take = s_axi_awvalid && awready_r;
  assign w_take = s_axi_wvalid && wready_r;
  // either order: address and data may land in different cycles
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  always_comb
  begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    peripheral_irq_enable_one_nxt = peripheral_irq_enable_one_r;
    if (aw_take)
    begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (w_take)
    begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = irq_enable_pkg::RESP_OKAY;
      // the 8-bit register fills byte lane 0 of its own word
      if (at_index(aw_addr_r, irq_enable_pkg::ENABLE_ONE_OFFSET))
      begin
        if (w_strb_r[0])
          peripheral_irq_enable_one_nxt = w_data_r[7:0];
      end
      else if (!is_mapped(aw_addr_r))
        bresp_nxt = irq_enable_pkg::RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    // ready low while a half is held, so at most one write is under way
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= irq_enable_pkg::RESP_OKAY;
      peripheral_irq_enable_one_r <= irq_enable_pkg::ENABLE_ONE_RESET;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      peripheral_irq_enable_one_r <= peripheral_irq_enable_one_nxt;
    end
  end

  // ==========================================================================
  // read channel
  // ==========================================================================
  logic arready_r;
  logic arready_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  irq_enable_pkg::read_answer_t rans_r;
  irq_enable_pkg::read_answer_t rans_nxt;
  logic [7:0] gated_w;
  logic request_w;

  function automatic irq_enable_pkg::read_answer_t read_word(
    input logic [11:0] addr,
    input logic [7:0] enables,
    input logic [7:0] flag_bits,
    input logic req
  );
    irq_enable_pkg::read_answer_t ans;
    ans.resp = irq_enable_pkg::RESP_OKAY;
    ans.data = irq_enable_pkg::UNMAPPED_READ_VALUE;
    if (at_index(addr, irq_enable_pkg::ENABLE_ONE_OFFSET))
      ans.data = {24'h000000, enables};
    else if (at_index(addr, irq_enable_pkg::FLAGS_OFFSET))
      ans.data = {24'h000000, flag_bits};
    else if (at_index(addr, irq_enable_pkg::REQUEST_OFFSET))
      ans.data = {31'h00000000, req};
    else
      ans.resp = irq_enable_pkg::RESP_SLVERR;
    read_word = ans;
  endfunction

  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rans_nxt = rans_r;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rans_nxt = read_word(s_axi_araddr, peripheral_irq_enable_one_r, flags_sync_r, request_w);
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rans_r <= '0;
    end
    else
    begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rans_r <= rans_nxt;
    end
  end

  // ==========================================================================
  // gating of flags by enables
  // ==========================================================================
  irq_gate #(
    .SOURCES(8)
  ) u_gate (
    .clk(clk),
    .arst_n(arst_n),
    .flags(flags_sync_r),
    .enables(peripheral_irq_enable_one_r),
    .gated_r(gated_w),
    .request_r(request_w)
  );

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rans_r.data;
  assign s_axi_rresp = rans_r.resp;
  assign gated_flags = gated_w;
  assign periph_irq_req = request_w;

endmodule

`default_nettype wire

// file: tb.sv
// self-checking bench of the peripheral interrupt enable bank
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %0t: mismatch got %h exp %h", $time, got, exp); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // byte address of each register: four times its word index
  localparam logic [11:0] ENABLE_ADDR = {irq_enable_pkg::ENABLE_ONE_OFFSET[9:0], 2'h0};
  localparam logic [11:0] FLAGS_ADDR = {irq_enable_pkg::FLAGS_OFFSET[9:0], 2'h0};
  localparam logic [11:0] REQUEST_ADDR = {irq_enable_pkg::REQUEST_OFFSET[9:0], 2'h0};
  logic clk, arst_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, periph_irq_req;
  logic port_b_change_flag, timer_three_flag, timer_two_flag, timer_one_flag;
  logic capture_two_flag, capture_one_flag, serial_one_tx_empty_flag, serial_one_rx_full_flag;
  logic [7:0] gated_flags, want;
  int miscompares, checks_done, cycles;

  peripheral_irq_enable_bank u_peripheral_irq_enable_bank (.*);
  flag_source u_flag_source (.*);

  // ==========================================================================
  // clock, timeout and verdict
  // ==========================================================================
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // bus master tasks
  // ==========================================================================
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid)
      @(posedge clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid)
      @(posedge clk);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // the enable register fills byte lane 0 of its word
  task chk_reg(input logic [7:0] e);
    rd(ENABLE_ADDR);
    `CHK(rd_data, {24'h000000, e})
    `CHK(resp, irq_enable_pkg::RESP_OKAY)
  endtask

  // one edge in the model, two sync flops and the gate
  task flags_chk(input logic [7:0] f, input logic [7:0] en);
    want <= f;
    repeat (5) @(posedge clk);
    `CHK(gated_flags, f & en)
    `CHK(periph_irq_req, |(f & en))
  endtask

  // ==========================================================================
  // tests
  // ==========================================================================
  initial
  begin
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, want} = 68'h0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    chk_reg(irq_enable_pkg::ENABLE_ONE_RESET);
    for (int i = 0; i < 8; i++)
    begin
      wr(ENABLE_ADDR, 32'h00000001 << i, 4'h1);
      `CHK(resp, irq_enable_pkg::RESP_OKAY)
      chk_reg(8'h01 << i);
      flags_chk(8'hFF, 8'h01 << i);
      flags_chk(~(8'h01 << i), 8'h01 << i);
    end
    wr(ENABLE_ADDR, 32'h000000A5, 4'h1);
    flags_chk(8'h3C, 8'hA5);
    rd(REQUEST_ADDR);
    `CHK(rd_data, 32'h00000001)
    flags_chk(8'h5A, 8'hA5);
    wr(ENABLE_ADDR, 32'hFFFFFFFF, 4'hE);
    chk_reg(8'hA5);
    rd(FLAGS_ADDR);
    `CHK(rd_data, 32'h0000005A)
    rd(REQUEST_ADDR);
    `CHK(rd_data, 32'h00000000)
    wr(12'h100, 32'hFFFFFFFF, 4'hF);
    `CHK(resp, irq_enable_pkg::RESP_SLVERR)
    rd(12'h100);
    `CHK(resp, irq_enable_pkg::RESP_SLVERR)
    `CHK(rd_data, irq_enable_pkg::UNMAPPED_READ_VALUE)
    chk_reg(8'hA5);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    chk_reg(8'h00);
    flags_chk(8'hFF, 8'h00);
    close_out();
  end
endmodule

bind peripheral_irq_enable_bank irq_enable_properties u_irq_enable_properties (.*);

`default_nettype wire
